// File: sadc_analog_model.sv
module sadc_analog_model import sadc_pkg::*; (
	input  wire logic         clk_i,
	input  wire sadc_analog_t analog_i,
	input  wire logic [39:0]  vin_i,
	output logic              comp_hi_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Sample-hold and comparator
	// ----------------------------------------------------------------
	logic       toggle_r = 1'b0;
	logic [9:0] held_r   = 10'h000;

	// An unpowered comparator gives no decision, so the line wanders.
	always_ff @(posedge clk_i) begin
		toggle_r <= ~toggle_r;
	end

	always_ff @(posedge clk_i) begin
		if (analog_i.sample) begin
			held_r <= vin_i[analog_i.channel*10 +: 10];
		end
	end

	always_comb begin
		if (analog_i.comp_power) begin
			comp_hi_o = (held_r >= analog_i.tap);
		end else begin
			comp_hi_o = toggle_r;
		end
	end
endmodule

// File: sadc_consts.svh
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SADC_ADDR_RES_LO     16'hFF08
`define SADC_ADDR_RES_HI     16'hFF09
`define SADC_ADDR_RES_BYTE   16'hFF0A
`define SADC_ADDR_MODE       16'hFF28
`define SADC_ADDR_CHAN       16'hFF29

// ----------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------
`define SADC_MODE_RESET      8'h00
`define SADC_CHAN_RESET      2'h0
`define SADC_RES_RESET       10'h000
`define SADC_MODE_WMASK      8'hBF
`define SADC_CHAN_WMASK      8'h03
`define SADC_RES_PAD         6'h00

// ----------------------------------------------------------------
// Conversion timing
// ----------------------------------------------------------------
`define SADC_RES_BITS        10
`define SADC_SAMPLE_CLKS     12
`define SADC_CONV_CLKS       22
`define SADC_LV_NORMAL       2'h1
`define SADC_SPEED_MAX       3'h5
`define SADC_DIV_0           4'hC
`define SADC_DIV_1           4'h8
`define SADC_DIV_2           4'h6
`define SADC_DIV_3           4'h4
`define SADC_DIV_4           4'h3
`define SADC_DIV_5           4'h2
`define SADC_CLK_PERIOD_NS   25
`define SADC_COMP_SETTLE_NS  1000

`endif

// File: sadc_ctrl.sv
// What this block does
// - Mode bit 7 stops conversion at 0 and enables it at 1.
// - Run and comparator enable both 0: comparator unpowered, no conversion.
// - Comparator enable 1, run 0: only the comparator is powered, waiting.
// - Run without comparator enable still converts; first result flagged for discard.
// - Comparator needs 1 us to settle; earlier conversions are unreliable.
// - Speed codes 0 to 5 give 264..44 clocks, divider 12,8,6,4,3,2.
// - Mode register write inserts a bus wait cycle.
// - Mode and channel registers take single-bit and byte writes.
// - Wide result holds 10 bits left-justified; low 6 bits read zero.
// - Result bits 9..2 at high byte, bits 1..0 at low byte bits 7..6.
// - Every conversion end copies the approximation into both result registers.
// - Byte result presents the top eight result bits, byte read.
// - Reading the wide result inserts a bus wait cycle.
// - Channel field bits 1..0 select analog input 0 to 3.
// - Channel register write inserts a bus wait cycle.
// - Conversions repeat while run stays 1; clearing run stops them.
// - Each finished conversion raises the conversion-complete interrupt request.
// - Approximation resolves bit 9 to 0, keeping a bit when input meets tap.
`include "sadc_consts.svh"
module sadc_ctrl import sadc_pkg::*; #(
	parameter int CLK_PERIOD_NS = `SADC_CLK_PERIOD_NS
) (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic [15:0]  addr_i,
	input  wire logic [7:0]   wdata_i,
	input  wire logic         wr_i,
	input  wire logic         bit_wr_i,
	input  wire logic [2:0]   bit_sel_i,
	input  wire logic         bit_val_i,
	input  wire logic         rd_i,
	input  wire logic         rd16_i,
	input  wire logic         comp_hi_i,
	output logic [15:0]       rdata_o,
	output logic              wait_o,
	output sadc_analog_t      analog_o,
	output logic              conv_done_irq_o,
	output logic              discard_o
);
	// ----------------------------------------------------------------
	// Constants
	// ----------------------------------------------------------------
	localparam int SETTLE_INT =
		(`SADC_COMP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] SETTLE_CYC = 7'(SETTLE_INT);
	localparam logic [8:0] CONV_CLKS  = 9'(`SADC_CONV_CLKS);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sadc_mode_t   mode_r;
	logic [1:0]   chan_r;
	logic [9:0]   res_r;
	logic [6:0]   settle_cnt_r;
	logic [3:0]   div_cnt_r;
	logic         bad_r;
	logic [15:0]  rdata_r;
	logic         wait_r;
	logic         irq_r;
	logic         discard_r;
	sadc_analog_t analog_r;
	logic [8:0]   gap_r;
	logic         gap_ok_r;

	logic         speed_ok;
	logic         run_ok;
	logic         stable;
	logic [3:0]   div;
	logic         conv_ce;
	logic         wr_any;
	logic         core_busy;
	logic         core_sample;
	logic         core_start;
	logic         core_done;
	logic [9:0]   core_tap;
	logic [9:0]   core_result;

	// ----------------------------------------------------------------
	// Write merge
	// ----------------------------------------------------------------
	// A single-bit write touches one bit and keeps the rest.
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
		logic [7:0] val;
		val = old;
		if (bit_wr_i) begin
			val[bit_sel_i] = bit_val_i;
		end else begin
			val = wdata_i;
		end
		return val & mask;
	endfunction

	assign wr_any = wr_i | bit_wr_i;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mode_r <= sadc_mode_t'(`SADC_MODE_RESET);
		end else if (wr_any && addr_i == `SADC_ADDR_MODE) begin
			mode_r <= sadc_mode_t'(merge(mode_r, `SADC_MODE_WMASK));
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			chan_r <= `SADC_CHAN_RESET;
		end else if (wr_any && addr_i == `SADC_ADDR_CHAN) begin
			chan_r <= 2'(merge({6'h00, chan_r}, `SADC_CHAN_WMASK));
		end
	end

	// ----------------------------------------------------------------
	// Speed selection and conversion clock divider
	// ----------------------------------------------------------------
	// Prohibited speed codes hold the converter idle rather than guess a rate.
	assign speed_ok = (mode_r.low_voltage_sel == `SADC_LV_NORMAL)
		&& (mode_r.speed_sel <= `SADC_SPEED_MAX);
	assign run_ok = mode_r.run_bit & speed_ok;

	always_comb begin
		case (mode_r.speed_sel)
			3'h0: div = `SADC_DIV_0;
			3'h1: div = `SADC_DIV_1;
			3'h2: div = `SADC_DIV_2;
			3'h3: div = `SADC_DIV_3;
			3'h4: div = `SADC_DIV_4;
			3'h5: div = `SADC_DIV_5;
			default: div = `SADC_DIV_0;
		endcase
	end

	assign conv_ce = run_ok && (div_cnt_r == div - 4'h1);

	always_ff @(posedge clk_i) begin
		if (reset_i || !run_ok) begin
			div_cnt_r <= 4'h0;
		end else if (conv_ce) begin
			div_cnt_r <= 4'h0;
		end else begin
			div_cnt_r <= div_cnt_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Comparator settling
	// ----------------------------------------------------------------
	// The comparator is powered whenever either bit asks for it.
	always_ff @(posedge clk_i) begin
		if (reset_i || !(mode_r.run_bit || mode_r.comparator_enable)) begin
			settle_cnt_r <= 7'h00;
		end else if (settle_cnt_r != SETTLE_CYC) begin
			settle_cnt_r <= settle_cnt_r + 7'h01;
		end
	end

	assign stable = (settle_cnt_r == SETTLE_CYC);

	// A conversion begun before the comparator settled is marked bad.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bad_r <= 1'b0;
		end else if (core_start) begin
			bad_r <= !stable;
		end
	end

	// ----------------------------------------------------------------
	// Approximation sequencer
	// ----------------------------------------------------------------
	sadc_sar_core #(
		.RES_BITS (`SADC_RES_BITS)
	) u_core (
		.clk_i     (clk_i),
		.reset_i   (reset_i),
		.go_i      (run_ok),
		.ce_i      (conv_ce),
		.comp_hi_i (comp_hi_i),
		.busy_o    (core_busy),
		.sample_o  (core_sample),
		.start_o   (core_start),
		.done_o    (core_done),
		.tap_o     (core_tap),
		.result_o  (core_result)
	);

	// ----------------------------------------------------------------
	// Results and completion
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			res_r     <= `SADC_RES_RESET;
			irq_r     <= 1'b0;
			discard_r <= 1'b0;
		end else begin
			irq_r <= core_done;
			if (core_done) begin
				res_r     <= core_result;
				discard_r <= bad_r;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			analog_r <= '0;
		end else begin
			analog_r.comp_power <= mode_r.run_bit | mode_r.comparator_enable;
			analog_r.sample     <= core_sample;
			analog_r.tap        <= core_tap;
			analog_r.channel    <= chan_r;
		end
	end

	// ----------------------------------------------------------------
	// Register reads and bus wait
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_r <= 16'h0000;
		end else if (rd16_i && addr_i == `SADC_ADDR_RES_LO) begin
			rdata_r <= {res_r, `SADC_RES_PAD};
		end else if (rd_i) begin
			case (addr_i)
				`SADC_ADDR_RES_LO:   rdata_r <= {8'h00, res_r[1:0], `SADC_RES_PAD};
				`SADC_ADDR_RES_HI:   rdata_r <= {8'h00, res_r[9:2]};
				`SADC_ADDR_RES_BYTE: rdata_r <= {8'h00, res_r[9:2]};
				`SADC_ADDR_MODE:     rdata_r <= {8'h00, mode_r};
				`SADC_ADDR_CHAN:     rdata_r <= {14'h0, chan_r};
				default:             rdata_r <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= (wr_any && addr_i == `SADC_ADDR_MODE)
				|| (wr_any && addr_i == `SADC_ADDR_CHAN)
				|| ((rd16_i || rd_i) && addr_i == `SADC_ADDR_RES_LO)
				|| (rd_i && addr_i == `SADC_ADDR_RES_HI);
		end
	end

	assign rdata_o         = rdata_r;
	assign wait_o          = wait_r;
	assign analog_o        = analog_r;
	assign conv_done_irq_o = irq_r;
	assign discard_o       = discard_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i || !run_ok) begin
			gap_r    <= 9'h000;
			gap_ok_r <= 1'b0;
		end else if (core_done) begin
			gap_r    <= 9'h001;
			gap_ok_r <= 1'b1;
		end else begin
			gap_r <= gap_r + 9'h001;
		end
	end

	AST_RUN_OFF_STOPS:
	assert property (@(posedge clk_i) disable iff (reset_i)
		!mode_r.run_bit |=> !core_busy)
		else $error("converter busy after run bit cleared");

	AST_IDLE_UNPOWERED:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(!mode_r.run_bit && !mode_r.comparator_enable)[*2] |-> !analog_o.comp_power && !core_busy)
		else $error("comparator powered or busy while idle");

	AST_WAITING_MODE:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(mode_r.comparator_enable && !mode_r.run_bit)[*2] |-> analog_o.comp_power && !core_busy)
		else $error("waiting mode not held");

	AST_EARLY_START_BAD:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(core_start && settle_cnt_r < SETTLE_CYC) |=> bad_r)
		else $error("early conversion not marked");

	AST_DISCARD_FLAG:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(core_done && bad_r) |=> discard_o && conv_done_irq_o)
		else $error("bad first result not flagged");

	AST_CONV_LENGTH:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(core_done && gap_ok_r) |-> gap_r == CONV_CLKS * {5'h00, div})
		else $error("conversion length wrong");

	AST_RESULT_COPY:
	assert property (@(posedge clk_i) disable iff (reset_i)
		core_done |=> res_r == $past(core_result))
		else $error("result not copied at conversion end");

	AST_IRQ_PULSE:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(core_done && !$past(core_done)) |=> conv_done_irq_o ##1 !conv_done_irq_o)
		else $error("completion request not a single pulse");

	AST_WIDE_READ:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(rd16_i && addr_i == `SADC_ADDR_RES_LO) |=>
		rdata_o[5:0] == 6'h00 && rdata_o[15:6] == $past(res_r) && wait_o)
		else $error("wide result read wrong");

	AST_BYTE_READ:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(rd_i && !rd16_i && addr_i == `SADC_ADDR_RES_BYTE) |=>
		rdata_o == {8'h00, $past(res_r[9:2])})
		else $error("byte result read wrong");

	AST_MODE_WAIT:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(wr_any && addr_i == `SADC_ADDR_MODE) |=> wait_o
		##1 (!wait_o || $past(wr_any || rd_i || rd16_i)))
		else $error("mode write gave no wait");

	AST_BIT6_ZERO:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(wr_any && addr_i == `SADC_ADDR_MODE) |=> !mode_r.zero6)
		else $error("mode bit 6 set");

	AST_CHANNEL_OUT:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(wr_i && !bit_wr_i && addr_i == `SADC_ADDR_CHAN) |=> ##1 analog_o.channel == $past(wdata_i[1:0], 2))
		else $error("channel select not applied");

endmodule

// File: sadc_pkg.sv
package sadc_pkg;

	// Mode register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic       run_bit;
		logic       zero6;
		logic [2:0] speed_sel;
		logic [1:0] low_voltage_sel;
		logic       comparator_enable;
	} sadc_mode_t;

	// Signals toward the sample-hold, ladder tap selector and comparator.
	typedef struct packed {
		logic       comp_power;
		logic       sample;
		logic [9:0] tap;
		logic [1:0] channel;
	} sadc_analog_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_TRIAL  = 3'b100
	} sadc_state_t;

endpackage

// File: sadc_sar_core.sv
`include "sadc_consts.svh"
module sadc_sar_core import sadc_pkg::*; #(
	parameter int RES_BITS = `SADC_RES_BITS
) (
	input  wire logic                clk_i,
	input  wire logic                reset_i,
	input  wire logic                go_i,
	input  wire logic                ce_i,
	input  wire logic                comp_hi_i,
	output logic                     busy_o,
	output logic                     sample_o,
	output logic                     start_o,
	output logic                     done_o,
	output logic [RES_BITS-1:0]      tap_o,
	output logic [RES_BITS-1:0]      result_o
);
	localparam logic [3:0] LAST_SAMPLE = 4'(`SADC_SAMPLE_CLKS - 1);
	localparam logic [3:0] TOP_BIT     = 4'(RES_BITS - 1);

	sadc_state_t         state_r;
	logic [3:0]          cnt_r;
	logic [RES_BITS-1:0] sar_r;
	logic [RES_BITS-1:0] kept;
	logic [RES_BITS-1:0] trial_nxt;

	// ----------------------------------------------------------------
	// Trial bit decision
	// ----------------------------------------------------------------
	for (genvar gi = 0; gi < RES_BITS; gi++) begin : g_bit
		assign kept[gi]      = (4'(gi) == cnt_r) ? comp_hi_i : sar_r[gi];
		assign trial_nxt[gi] = kept[gi] | ((cnt_r != 4'h0) && (4'(gi) == cnt_r - 4'h1));
	end

	assign busy_o   = (state_r != ST_IDLE);
	assign sample_o = (state_r == ST_SAMPLE);
	assign tap_o    = sar_r;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Dropping go aborts at once; a half-resolved value is never transferred.
	always_ff @(posedge clk_i) begin
		start_o <= 1'b0;
		done_o  <= 1'b0;
		if (reset_i || !go_i) begin
			state_r <= ST_IDLE;
			cnt_r   <= 4'h0;
			sar_r   <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					state_r <= ST_SAMPLE;
					cnt_r   <= 4'h0;
					sar_r   <= '0;
					start_o <= 1'b1;
				end
				ST_SAMPLE: begin
					if (ce_i && cnt_r == LAST_SAMPLE) begin
						state_r <= ST_TRIAL;
						cnt_r   <= TOP_BIT;
						sar_r   <= {1'b1, {(RES_BITS-1){1'b0}}};
					end else if (ce_i) begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				ST_TRIAL: begin
					if (ce_i && cnt_r == 4'h0) begin
						done_o  <= 1'b1;
						state_r <= ST_SAMPLE;
						cnt_r   <= 4'h0;
						sar_r   <= '0;
						start_o <= 1'b1;
					end else if (ce_i) begin
						sar_r <= trial_nxt;
						cnt_r <= cnt_r - 4'h1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			result_o <= '0;
		end else if (state_r == ST_TRIAL && ce_i && cnt_r == 4'h0 && go_i) begin
			result_o <= kept;
		end
	end

	AST_FIRST_TRIAL_MSB:
	assert property (@(posedge clk_i) disable iff (reset_i)
		(go_i && state_r == ST_SAMPLE && ce_i && cnt_r == LAST_SAMPLE)
		|=> (state_r == ST_TRIAL && sar_r == {1'b1, {(RES_BITS-1){1'b0}}}))
		else $error("first trial does not set the top bit");

endmodule

// File: testbench.sv
`include "sadc_consts.svh"
module testbench import sadc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic         clk       = 1'b0;
	logic         rst       = 1'b1;
	logic [15:0]  addr      = 16'h0000;
	logic [7:0]   wdata     = 8'h00;
	logic         wr        = 1'b0;
	logic         bwr       = 1'b0;
	logic [2:0]   bsel      = 3'h0;
	logic         bval      = 1'b0;
	logic         rd        = 1'b0;
	logic         rd16      = 1'b0;
	logic [39:0]  vin       = {10'h15A, 10'h2A5, 10'h0FF, 10'h301};
	logic         comp_hi;
	logic [15:0]  rdata;
	logic         wt;
	logic         last_wait = 1'b0;
	sadc_analog_t ana;
	logic         irq;
	logic         disc;
	logic [15:0]  got;
	int           mismatches = 0;
	int           checks     = 0;
	int           n;
	int           cyc[6]     = '{264, 176, 132, 88, 66, 44};

	always #12.5 clk = ~clk;

	sadc_ctrl dut (.clk_i(clk), .reset_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.bit_wr_i(bwr), .bit_sel_i(bsel), .bit_val_i(bval), .rd_i(rd), .rd16_i(rd16),
		.comp_hi_i(comp_hi), .rdata_o(rdata), .wait_o(wt), .analog_o(ana),
		.conv_done_irq_o(irq), .discard_o(disc));

	sadc_analog_model far (.clk_i(clk), .analog_i(ana), .vin_i(vin), .comp_hi_o(comp_hi));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		last_wait = wt;
	endtask

	task automatic bit_wr(input logic [15:0] a, input logic [2:0] s, input logic v);
		@(posedge clk);
		#1;
		addr = a;
		bsel = s;
		bval = v;
		bwr = 1'b1;
		@(posedge clk);
		#1;
		bwr = 1'b0;
		last_wait = wt;
	endtask

	task automatic bus_rd(input logic [15:0] a, input logic w, output logic [15:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd16 = w;
		rd = ~w;
		@(posedge clk);
		#1;
		rd16 = 1'b0;
		rd = 1'b0;
		d = rdata;
		last_wait = wt;
	endtask

	// A conversion that never ends closes the run instead of hanging it.
	task automatic wait_irq(input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			#1;
			cnt++;
		end while (irq !== 1'b1 && cnt < lim);
		if (irq !== 1'b1) begin
			mismatches++;
			$display("Error at %0t: no conversion end", $time);
			report_and_stop();
		end
	endtask

	task automatic quiet(input int c);
		repeat (c) begin
			@(posedge clk);
			#1;
			chk({15'h0000, irq}, 16'h0000);
		end
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		bus_rd(`SADC_ADDR_MODE, 1'b0, got);
		chk(got, 16'h0000);
		bus_rd(`SADC_ADDR_CHAN, 1'b0, got);
		chk(got, 16'h0000);
		bus_rd(`SADC_ADDR_RES_LO, 1'b1, got);
		chk(got, 16'h0000);
		chk({15'h0000, last_wait}, 16'h0001);
		bus_rd(16'h1234, 1'b0, got);
		chk(got, 16'h0000);
		$display("test reset done");

		bus_wr(`SADC_ADDR_MODE, 8'hFF);
		chk({15'h0000, last_wait}, 16'h0001);
		bus_rd(`SADC_ADDR_MODE, 1'b0, got);
		chk(got, 16'h00BF);
		bit_wr(`SADC_ADDR_MODE, 3'h6, 1'b1);
		bit_wr(`SADC_ADDR_MODE, 3'h7, 1'b0);
		bus_rd(`SADC_ADDR_MODE, 1'b0, got);
		chk(got, 16'h003F);
		bus_wr(`SADC_ADDR_MODE, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		chk({15'h0000, ana.comp_power}, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			bus_wr(`SADC_ADDR_CHAN, 8'(c));
			chk({15'h0000, last_wait}, 16'h0001);
			@(posedge clk);
			#1;
			chk({14'h0000, ana.channel}, 16'(c));
		end
		bus_wr(`SADC_ADDR_CHAN, 8'h02);
		bit_wr(`SADC_ADDR_CHAN, 3'h0, 1'b1);
		bus_rd(`SADC_ADDR_CHAN, 1'b0, got);
		chk(got, 16'h0003);
		$display("test registers done");

		bus_wr(`SADC_ADDR_CHAN, 8'h02);
		bus_wr(`SADC_ADDR_MODE, 8'h03);
		quiet(60);
		chk({15'h0000, ana.comp_power}, 16'h0001);
		$display("test waiting done");

		// Run is cleared before each new speed code is written.
		for (int s = 0; s < 6; s++) begin
			bit_wr(`SADC_ADDR_MODE, 3'h7, 1'b0);
			bus_wr(`SADC_ADDR_MODE, {2'b00, 3'(s), 2'b01, 1'b1});
			bus_wr(`SADC_ADDR_MODE, {2'b10, 3'(s), 2'b01, 1'b1});
			wait_irq(400, n);
			chk({15'h0000, disc}, 16'h0000);
			wait_irq(400, n);
			chk(n[15:0], cyc[s][15:0]);
		end
		bus_rd(`SADC_ADDR_RES_LO, 1'b1, got);
		chk(got, {10'h2A5, 6'h00});
		bus_rd(`SADC_ADDR_RES_HI, 1'b0, got);
		chk(got, 16'h00A9);
		bus_rd(`SADC_ADDR_RES_LO, 1'b0, got);
		chk(got, 16'h0040);
		bus_rd(`SADC_ADDR_RES_BYTE, 1'b0, got);
		chk(got, 16'h00A9);
		vin[29:20] = 10'h0C3;
		wait_irq(400, n);
		wait_irq(400, n);
		bus_rd(`SADC_ADDR_RES_BYTE, 1'b0, got);
		chk(got, 16'h0030);
		$display("test conversion done");

		wait_irq(400, n);
		repeat (20) @(posedge clk);
		bit_wr(`SADC_ADDR_MODE, 3'h7, 1'b0);
		quiet(100);
		bus_wr(`SADC_ADDR_MODE, 8'hB3);
		quiet(600);
		$display("test stop done");

		bus_wr(`SADC_ADDR_MODE, 8'h32);
		repeat (5) @(posedge clk);
		bus_wr(`SADC_ADDR_MODE, 8'hAA);
		wait_irq(200, n);
		chk({15'h0000, disc}, 16'h0001);
		bit_wr(`SADC_ADDR_MODE, 3'h7, 1'b0);
		$display("test discard done");
		report_and_stop();
	end
endmodule
